// >>> src/ctrl_regs_pkg.sv
// Constants and types for the chip control and status register bank
package ctrl_regs_pkg;
   localparam logic [7:0] OFS_ADDR_LOW = 8'h10;
   localparam logic [7:0] OFS_ADDR_MID = 8'h12;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h14;
   localparam logic [7:0] OFS_CHIP_CFG = 8'h08;
   localparam logic [7:0] OFS_BUS_CLK = 8'h20;
   localparam logic [7:0] OFS_PROM_CTRL = 8'h22;
   localparam logic [7:0] OFS_SELFTEST = 8'h24;
   localparam logic [7:0] OFS_SOFT_RST = 8'h26;
   // Field positions
   localparam int BIT_DRIVE = 6;
   localparam int BIT_CLK_SEL = 2;
   localparam int BIT_PROM_DIR = 5;
   localparam int BIT_PROM_EN = 4;
   localparam int BIT_PROM_DIN = 3;
   localparam int BIT_PROM_DO = 2;
   localparam int BIT_PROM_SK = 1;
   localparam int BIT_PROM_CS = 0;
   localparam int BIT_PRESENCE = 9;
   localparam int BIT_QM_RST = 1;
   localparam int BIT_GLB_RST = 0;
   localparam int BIT_TX_DONE = 12;
   localparam int BIT_TX_FAIL = 11;
   localparam int BIT_TX_CNT = 8;
   localparam int BIT_RX_DONE = 4;
   localparam int BIT_RX_FAIL = 3;
   localparam int BIT_RX_CNT = 0;
   localparam logic [1:0] DIV_RESERVED = 2'h3;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   // EEPROM word indices for the address load
   localparam logic [5:0] PROM_WORD_LOW = 6'h01;
   localparam logic [5:0] PROM_WORD_MID = 6'h02;
   localparam logic [5:0] PROM_WORD_HIGH = 6'h03;
   // Serial read opcode (start bit + read) and framing
   localparam logic [2:0] PROM_READ_OP = 3'h6;
   localparam int PROM_BITS = 25;
   // Loader clock half period: 1000 ns at 250 MHz
   localparam int PROM_HALF_NS = 1000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int PROM_HALF_CYC = PROM_HALF_NS / CLK_PERIOD_NS;
   // Self-test walks a small index space per memory
   localparam int BIST_WORDS = 16;

   typedef struct packed {
      logic dataOut;
      logic serialClk;
      logic chipSel;
   } prom_pins_s;

   typedef struct packed {
      logic done;
      logic failed;
      logic [2:0] failCount;
   } selftest_s;

   typedef struct packed {
      logic drive16mA;
      logic clkSel;
      logic [1:0] clkDiv;
   } bus_clk_s;
endpackage

// >>> src/prom_addr_loader.sv
// Serial EEPROM reader that fetches the three station address words
`timescale 1ns/1ns
module prom_addr_loader
   import ctrl_regs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic promDataIn,
   // Results
   output prom_pins_s pins,
   output logic wordValid,
   output logic [1:0] wordSel,
   output logic [15:0] wordData,
   output logic cmdDrive
);
   typedef enum logic [1:0] {
      L_IDLE = 2'b00,
      L_SHIFT = 2'b01,
      L_GAP = 2'b10
   } load_state_e;

   typedef struct packed {
      load_state_e state;
      logic [8:0] halfCnt;
      logic [4:0] bitIdx;
      logic [1:0] word;
      logic [24:0] shiftOut;
      logic [15:0] shiftIn;
      logic sk;
      logic cs;
      logic valid;
   } load_s;

   load_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      unique case (st_reg.state)
         L_IDLE: begin
            if (start) begin
               st_next.state = L_GAP;
               st_next.word = 2'h0;
               st_next.halfCnt = 9'h000;
            end
         end
         L_GAP: begin
            st_next.cs = 1'b0;
            st_next.sk = 1'b0;
            st_next.halfCnt = st_reg.halfCnt + 9'h001;
            if (st_reg.halfCnt == 9'(PROM_HALF_CYC - 1)) begin
               st_next.halfCnt = 9'h000;
               if (st_reg.word == 2'h3) begin
                  st_next.state = L_IDLE;
               end else begin
                  // words 1..3 map to low, mid, high
                  st_next.shiftOut = {PROM_READ_OP, PROM_WORD_LOW + 6'(st_reg.word), 16'h0000};
                  st_next.bitIdx = 5'h00;
                  st_next.cs = 1'b1;
                  st_next.state = L_SHIFT;
               end
            end
         end
         L_SHIFT: begin
            st_next.halfCnt = st_reg.halfCnt + 9'h001;
            if (st_reg.halfCnt == 9'(PROM_HALF_CYC - 1)) begin
               st_next.halfCnt = 9'h000;
               st_next.sk = ~st_reg.sk;
               if (st_reg.sk) begin
                  st_next.shiftOut = {st_reg.shiftOut[23:0], 1'b0};
                  st_next.bitIdx = st_reg.bitIdx + 5'h01;
                  if (st_reg.bitIdx == 5'(PROM_BITS - 1)) begin
                     st_next.valid = 1'b1;
                     st_next.word = st_reg.word + 2'h1;
                     st_next.state = L_GAP;
                  end
               end else if (st_reg.bitIdx > 5'(PROM_BITS - 17)) begin
                  st_next.shiftIn = {st_reg.shiftIn[14:0], promDataIn};
               end
            end
         end
         default: st_next.state = L_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pins.dataOut = st_reg.shiftOut[24];
   assign pins.serialClk = st_reg.sk;
   assign pins.chipSel = st_reg.cs;
   assign wordValid = st_reg.valid;
   // Word counter has already advanced when a word is flagged
   assign wordSel = st_reg.word - 2'h1;
   // Lower-numbered address byte already rides in the low half of each word
   assign wordData = st_reg.shiftIn;
   // Data line is released once the command is out, so the part can answer
   assign cmdDrive = st_reg.cs && st_reg.bitIdx < 5'(PROM_BITS - 16);
endmodule

// >>> src/chip_control_status_regs.sv
// Chip-level control and status register bank with EEPROM port and self-test
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module chip_control_status_regs
   import ctrl_regs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // EEPROM pins
   output logic promSerialClockPin,
   output logic promChipSelectPin,
   output logic promSerialDataOut,
   output logic promSerialDataOe,
   input wire logic promSerialDataIn,
   // Controls to the rest of the chip
   output logic [47:0] stationAddr,
   output logic drive16mA,
   output logic busClkSel,
   output logic [1:0] busClkDiv,
   output logic queueMgrReset,
   output logic globalReset
);
   typedef enum logic [1:0] {
      B_RUN = 2'b00,
      B_CHECK = 2'b01,
      B_DONE = 2'b10
   } bist_state_e;

   typedef struct packed {
      logic [15:0] addrLow;
      logic [15:0] addrMid;
      logic [15:0] addrHigh;
      bus_clk_s busClk;
      logic promEn;
      logic promDir;
      prom_pins_s promSw;
      logic presence;
      logic capDone;
      logic loadStarted;
      logic qmRst;
      logic glbRst;
      bist_state_e bist;
      logic [3:0] bistIdx;
      logic [15:0] txMem;
      logic [15:0] rxMem;
      selftest_s txTest;
      selftest_s rxTest;
      logic [15:0] rdata;
   } regs_s;

   regs_s st_reg, st_next;
   logic dinMeta, dinSync;
   prom_pins_s loadPins;
   logic loadValid, loadDrive;
   logic [1:0] loadSel;
   logic [15:0] loadData;

   // All checks run on the register clock and stay quiet while reset is held
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Saturating increment shared by both fail counters
   function automatic logic [2:0] satInc(input logic [2:0] v, input logic fail);
      satInc = (fail && v != 3'h7) ? v + 3'h1 : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser
   // Not reset, so it already carries the strap level when reset lets go
   always_ff @(posedge ref_clk) begin
      dinMeta <= promSerialDataIn;
      dinSync <= dinMeta;
   end

   prom_addr_loader u_loader (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(st_reg.capDone && st_reg.presence && !st_reg.loadStarted),
      .promDataIn(dinSync),
      .pins(loadPins),
      .wordValid(loadValid),
      .wordSel(loadSel),
      .wordData(loadData),
      .cmdDrive(loadDrive)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.rdata = ZERO16;
      // Presence taken at the first edge after release from the free-running synchroniser
      if (!st_reg.capDone) begin
         st_next.capDone = 1'b1;
         st_next.presence = dinSync;
      end
      if (st_reg.capDone && st_reg.presence) begin
         st_next.loadStarted = 1'b1;
      end
      if (loadValid) begin
         unique case (loadSel)
            2'h0: st_next.addrLow = loadData;
            2'h1: st_next.addrMid = loadData;
            2'h2: st_next.addrHigh = loadData;
            default: ;
         endcase
      end

      // Self-test: write pattern then read back, both memories in parallel
      unique case (st_reg.bist)
         B_RUN: begin
            st_next.txMem[st_reg.bistIdx] = st_reg.bistIdx[0];
            st_next.rxMem[st_reg.bistIdx] = ~st_reg.bistIdx[0];
            st_next.bistIdx = st_reg.bistIdx + 4'h1;
            if (st_reg.bistIdx == 4'(BIST_WORDS - 1)) begin
               st_next.bist = B_CHECK;
            end
         end
         B_CHECK: begin
            st_next.txTest.failCount = satInc(st_reg.txTest.failCount,
               st_reg.txMem[st_reg.bistIdx] != st_reg.bistIdx[0]);
            st_next.rxTest.failCount = satInc(st_reg.rxTest.failCount,
               st_reg.rxMem[st_reg.bistIdx] != ~st_reg.bistIdx[0]);
            st_next.bistIdx = st_reg.bistIdx + 4'h1;
            if (st_reg.bistIdx == 4'(BIST_WORDS - 1)) begin
               st_next.bist = B_DONE;
            end
         end
         B_DONE: begin
            st_next.txTest.done = 1'b1;
            st_next.rxTest.done = 1'b1;
            st_next.txTest.failed = st_reg.txTest.failCount != 3'h0;
            st_next.rxTest.failed = st_reg.rxTest.failCount != 3'h0;
         end
         default: st_next.bist = B_DONE;
      endcase

      // Writes only update registers; address writes send nothing to the EEPROM
      if (regWr) begin
         unique case (regAddr)
            OFS_ADDR_LOW: st_next.addrLow = regWdata;
            OFS_ADDR_MID: st_next.addrMid = regWdata;
            OFS_ADDR_HIGH: st_next.addrHigh = regWdata;
            OFS_BUS_CLK: begin
               st_next.busClk.drive16mA = regWdata[BIT_DRIVE];
               // Reserved select value and divider code are dropped
               if (!regWdata[BIT_CLK_SEL] && regWdata[1:0] != DIV_RESERVED) begin
                  st_next.busClk.clkDiv = regWdata[1:0];
               end
            end
            OFS_PROM_CTRL: begin
               st_next.promEn = regWdata[BIT_PROM_EN];
               st_next.promDir = regWdata[BIT_PROM_DIR];
               st_next.promSw = regWdata[BIT_PROM_DO:BIT_PROM_CS];
            end
            OFS_SOFT_RST: begin
               st_next.qmRst = regWdata[BIT_QM_RST];
               st_next.glbRst = regWdata[BIT_GLB_RST];
            end
            default: ;
         endcase
      end

      if (regRd) begin
         unique case (regAddr)
            OFS_CHIP_CFG: st_next.rdata[BIT_PRESENCE] = st_reg.presence;
            OFS_ADDR_LOW: st_next.rdata = st_reg.addrLow;
            OFS_ADDR_MID: st_next.rdata = st_reg.addrMid;
            OFS_ADDR_HIGH: st_next.rdata = st_reg.addrHigh;
            OFS_BUS_CLK: begin
               st_next.rdata[BIT_DRIVE] = st_reg.busClk.drive16mA;
               st_next.rdata[BIT_CLK_SEL] = st_reg.busClk.clkSel;
               st_next.rdata[1:0] = st_reg.busClk.clkDiv;
            end
            OFS_PROM_CTRL: begin
               // Direction bit is write-only and reads zero
               st_next.rdata[BIT_PROM_EN] = st_reg.promEn;
               st_next.rdata[BIT_PROM_DIN] = dinSync;
               st_next.rdata[BIT_PROM_DO:BIT_PROM_CS] = st_reg.promSw;
            end
            OFS_SELFTEST: begin
               st_next.rdata[BIT_TX_DONE] = st_reg.txTest.done;
               st_next.rdata[BIT_TX_FAIL] = st_reg.txTest.failed;
               st_next.rdata[BIT_TX_CNT +: 3] = st_reg.txTest.failCount;
               st_next.rdata[BIT_RX_DONE] = st_reg.rxTest.done;
               st_next.rdata[BIT_RX_FAIL] = st_reg.rxTest.failed;
               st_next.rdata[BIT_RX_CNT +: 3] = st_reg.rxTest.failCount;
            end
            OFS_SOFT_RST: begin
               st_next.rdata[BIT_QM_RST] = st_reg.qmRst;
               st_next.rdata[BIT_GLB_RST] = st_reg.glbRst;
            end
            default: st_next.rdata = ZERO16;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin ownership: software only while access is enabled
   always_comb begin
      if (st_reg.promEn) begin
         promSerialClockPin = st_reg.promSw.serialClk;
         promChipSelectPin = st_reg.promSw.chipSel;
         promSerialDataOut = st_reg.promSw.dataOut;
         promSerialDataOe = st_reg.promDir;
      end else begin
         promSerialClockPin = loadPins.serialClk;
         promChipSelectPin = loadPins.chipSel;
         promSerialDataOut = loadPins.dataOut;
         promSerialDataOe = loadDrive;
      end
   end

   assign regRdata = st_reg.rdata;
   assign stationAddr = {st_reg.addrHigh, st_reg.addrMid, st_reg.addrLow};
   assign drive16mA = st_reg.busClk.drive16mA;
   assign busClkSel = st_reg.busClk.clkSel;
   assign busClkDiv = st_reg.busClk.clkDiv;
   assign queueMgrReset = st_reg.qmRst;
   assign globalReset = st_reg.glbRst;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_mid_word_write: assert property (
      regWr && regAddr == OFS_ADDR_MID && !loadValid
      |=> stationAddr[31:16] == $past(regWdata))
      else $error("mid address word not written");

   chk_high_word_write: assert property (
      regWr && regAddr == OFS_ADDR_HIGH && !loadValid
      |=> stationAddr[47:32] == $past(regWdata))
      else $error("high address word not written");

   chk_low_word_write: assert property (
      regWr && regAddr == OFS_ADDR_LOW && !loadValid
      |=> stationAddr[15:0] == $past(regWdata))
      else $error("low address word not written");

   chk_load_mid_word: assert property (
      loadValid && loadSel == 2'h1 && !(regWr && regAddr == OFS_ADDR_MID)
      |=> stationAddr[31:16] == $past(loadData))
      else $error("loaded mid word not stored");

   chk_load_low_word: assert property (
      loadValid && loadSel == 2'h0 && !(regWr && regAddr == OFS_ADDR_LOW)
      |=> stationAddr[15:0] == $past(loadData))
      else $error("loaded low word not stored");

   chk_no_load: assert property (
      st_reg.capDone && !st_reg.presence && !st_reg.promEn
      |-> !promChipSelectPin)
      else $error("loader ran without a fitted part");

   chk_clk_sel_fixed: assert property (
      !busClkSel)
      else $error("reserved clock select taken");

   chk_div_write: assert property (
      regWr && regAddr == OFS_BUS_CLK && !regWdata[BIT_CLK_SEL]
      && regWdata[1:0] != DIV_RESERVED |=> busClkDiv == $past(regWdata[1:0]))
      else $error("divider code not taken");

   chk_div_not_reserved: assert property (
      busClkDiv != DIV_RESERVED)
      else $error("reserved divider code taken");

   chk_div_hold: assert property (
      regWr && regAddr == OFS_BUS_CLK
      && (regWdata[BIT_CLK_SEL] || regWdata[1:0] == DIV_RESERVED)
      |=> $stable(busClkDiv) && $stable(busClkSel))
      else $error("reserved clock write took effect");

   chk_drive_write: assert property (
      regWr && regAddr == OFS_BUS_CLK |=> drive16mA == $past(regWdata[BIT_DRIVE]))
      else $error("drive strength not updated");

   chk_sw_pins: assert property (
      regWr && regAddr == OFS_PROM_CTRL && regWdata[BIT_PROM_EN]
      |=> promChipSelectPin == $past(regWdata[BIT_PROM_CS])
      && promSerialClockPin == $past(regWdata[BIT_PROM_SK]))
      else $error("software pin drive lost");

   chk_sw_dir: assert property (
      regWr && regAddr == OFS_PROM_CTRL && regWdata[BIT_PROM_EN]
      |=> promSerialDataOe == $past(regWdata[BIT_PROM_DIR]))
      else $error("direction bit not applied");

   chk_din_live: assert property (
      regRd && regAddr == OFS_PROM_CTRL |=> regRdata[BIT_PROM_DIN] == $past(dinSync))
      else $error("data pin status not live");

   chk_rdata_idle: assert property (
      !regRd |=> regRdata == ZERO16)
      else $error("read data outside the read slot");

   chk_presence_hold: assert property (
      st_reg.capDone |=> st_reg.presence == $past(st_reg.presence))
      else $error("presence bit changed after capture");

   chk_soft_rst_level: assert property (
      regWr && regAddr == OFS_SOFT_RST |=> globalReset == $past(regWdata[BIT_GLB_RST])
      && queueMgrReset == $past(regWdata[BIT_QM_RST]))
      else $error("soft reset level wrong");

   chk_qm_rst_hold: assert property (
      !(regWr && regAddr == OFS_SOFT_RST) |=> $stable(queueMgrReset))
      else $error("queue reset changed without a write");

   chk_glb_rst_hold: assert property (
      !(regWr && regAddr == OFS_SOFT_RST) |=> $stable(globalReset))
      else $error("global reset changed without a write");

   chk_bist_finish: assert property (
      $rose(rst_n) |-> ##[1:40] (st_reg.txTest.done && st_reg.rxTest.done))
      else $error("self-test did not finish");

   chk_done_sticky: assert property (
      st_reg.txTest.done && st_reg.rxTest.done |=> st_reg.txTest.done && st_reg.rxTest.done)
      else $error("self-test finish flag dropped");

   chk_tx_fail_flag: assert property (
      st_reg.txTest.done |-> st_reg.txTest.failed == (st_reg.txTest.failCount != 3'h0))
      else $error("transmit fail flag wrong");

   chk_rx_fail_flag: assert property (
      st_reg.rxTest.done |-> st_reg.rxTest.failed == (st_reg.rxTest.failCount != 3'h0))
      else $error("receive fail flag wrong");

   chk_reserved_zero: assert property (
      regRd && regAddr == OFS_SELFTEST |=> regRdata[15:13] == 3'h0 && regRdata[7:5] == 3'h0)
      else $error("reserved bits not zero");
endmodule

// >>> dv/prom_model.sv
// Behavioural serial EEPROM that answers read frames on the device's pins
`timescale 1ns/1ns
module prom_model
(
   // Pins seen from the device
   input wire logic promClk,
   input wire logic promSel,
   input wire logic promDin,
   // Drive back onto the data line
   output logic promDout,
   output logic promDoe
);
   logic [15:0] memWord [0:63];
   logic [8:0] cmdReg;
   int bitCnt;
   int frameCnt;

   initial begin
      for (int i = 0; i < 64; i++) begin
         memWord[i] = 16'h0000;
      end
      memWord[1] = 16'h89ab;
      memWord[2] = 16'h4567;
      memWord[3] = 16'h0123;
      cmdReg = 9'h000;
      bitCnt = 0;
      frameCnt = 0;
      promDout = 1'b0;
      promDoe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // Dropping select aborts the frame and frees the data line
   always @(negedge promSel) begin
      bitCnt = 0;
      promDoe = 1'b0;
   end

   always @(posedge promClk) begin
      if (promSel) begin
         if (bitCnt < 9) begin
            cmdReg = {cmdReg[7:0], promDin};
         end
         bitCnt = bitCnt + 1;
         if (bitCnt == 9) begin
            frameCnt = frameCnt + 1;
         end
      end
   end

   // Data changes on the falling clock so it is settled at the next rise
   always @(negedge promClk) begin
      if (promSel && bitCnt >= 9 && bitCnt < 25 && cmdReg[8:6] == 3'h6) begin
         promDoe = 1'b1;
         promDout = memWord[cmdReg[5:0]][24 - bitCnt];
      end else begin
         promDoe = 1'b0;
      end
   end
endmodule

// >>> dv/chip_control_status_regs_tb.sv
// Self-checking testbench for the chip control and status register bank
`timescale 1ns/1ns
module chip_control_status_regs_tb
   import ctrl_regs_pkg::*;
;
   logic ref_clk, rst_n, regWr, regRd, pullUp;
   logic [7:0] regAddr;
   logic [15:0] regWdata, regRdata, rdVal, word;
   logic promSerialClockPin, promChipSelectPin, promSerialDataOut, promSerialDataOe;
   logic promDout, promDoe, pinLevel, drive16mA, busClkSel, queueMgrReset, globalReset;
   logic [47:0] stationAddr;
   logic [1:0] busClkDiv;
   int errorCnt, samplesChecked, cycleCnt, frames;

   // Unpulled wire resolution: device first, then EEPROM, then the strap resistor
   assign pinLevel = promSerialDataOe ? promSerialDataOut : (promDoe ? promDout : pullUp);

   chip_control_status_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .promSerialClockPin(promSerialClockPin), .promChipSelectPin(promChipSelectPin),
      .promSerialDataOut(promSerialDataOut), .promSerialDataOe(promSerialDataOe),
      .promSerialDataIn(pinLevel), .stationAddr(stationAddr), .drive16mA(drive16mA),
      .busClkSel(busClkSel), .busClkDiv(busClkDiv), .queueMgrReset(queueMgrReset),
      .globalReset(globalReset));

   prom_model i_prom (.promClk(promSerialClockPin), .promSel(promChipSelectPin),
      .promDin(pinLevel), .promDout(promDout), .promDoe(promDoe));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 rdVal = regRdata;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      rd(OFS_BUS_CLK);
      chk(rdVal, 0, "bus clock reset");
      rd(OFS_PROM_CTRL);
      chk(rdVal & 16'hfff7, 0, "prom ctrl reset");
      rd(OFS_SOFT_RST);
      chk(rdVal, 0, "soft reset reset");
      rd(OFS_CHIP_CFG);
      chk(rdVal & 16'h0200, 16'h0200, "presence set");
      rd(8'h16);
      chk(rdVal, 0, "unmapped read");
      repeat (40) @(posedge ref_clk);
      rd(OFS_SELFTEST);
      chk(rdVal, 16'h1010, "self-test result");
      $display("test reset values done");
   endtask

   task automatic t_load();
      for (int i = 0; i < 45000 && stationAddr !== 48'h0123_4567_89ab; i++) begin
         @(posedge ref_clk);
      end
      chk(stationAddr, 48'h0123_4567_89ab, "loaded address");
      rd(OFS_ADDR_LOW);
      chk(rdVal, 16'h89ab, "low word");
      rd(OFS_ADDR_MID);
      chk(rdVal, 16'h4567, "mid word");
      rd(OFS_ADDR_HIGH);
      chk(rdVal, 16'h0123, "high word");
      $display("test address load done");
   endtask

   task automatic t_addr_rw();
      frames = i_prom.frameCnt;
      wr(OFS_ADDR_MID, 16'hbeef);
      wr(OFS_ADDR_HIGH, 16'hffff);
      rd(OFS_ADDR_MID);
      chk(rdVal, 16'hbeef, "mid readback");
      rd(OFS_ADDR_HIGH);
      chk(rdVal, 16'hffff, "high readback");
      chk(stationAddr, 48'hffff_beef_89ab, "address out");
      chk(i_prom.frameCnt, frames, "no prom traffic");
      $display("test address rw done");
   endtask

   task automatic t_bus_clk();
      logic [15:0] wv [5] = '{16'h0041, 16'h0002, 16'h0003, 16'h0004, 16'h0040};
      logic [15:0] ev [5] = '{16'h0041, 16'h0002, 16'h0002, 16'h0002, 16'h0040};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_BUS_CLK, wv[i]);
         chk({drive16mA, busClkSel, busClkDiv}, {ev[i][6], ev[i][2:0]}, "clock outputs");
         rd(OFS_BUS_CLK);
         chk(rdVal, ev[i], "clock readback");
      end
      $display("test bus clock done");
   endtask

   task automatic bb(input logic drv, input logic d, input logic sk);
      wr(OFS_PROM_CTRL, {10'h000, drv, 1'b1, 1'b0, d, sk, 1'b1});
   endtask

   task automatic t_prom_sw();
      logic [24:0] frame;
      wr(OFS_PROM_CTRL, 16'h0007);
      chk({promChipSelectPin, promSerialClockPin, promSerialDataOe}, 0, "pins kept");
      wr(OFS_PROM_CTRL, 16'h0035);
      repeat (4) @(posedge ref_clk);
      chk({promSerialDataOe, promSerialDataOut, promChipSelectPin}, 3'h7, "sw drive");
      rd(OFS_PROM_CTRL);
      chk(rdVal & 16'h0028, 16'h0008, "live pin high, dir hidden");
      wr(OFS_PROM_CTRL, 16'h0031);
      repeat (4) @(posedge ref_clk);
      rd(OFS_PROM_CTRL);
      chk(rdVal & 16'h0008, 0, "live pin low");
      wr(OFS_PROM_CTRL, 16'h0021);
      chk({promSerialDataOe, promChipSelectPin}, 0, "disabled dir");
      // Bit-banged read of word 2 proves the pins and the status bit end to end
      frame = {3'h6, 6'h02, 16'h0000};
      word = 16'h0000;
      wr(OFS_PROM_CTRL, 16'h0010);
      for (int i = 0; i < 25; i++) begin
         // Direction high only while the command bits go out, then the part answers
         bb(i < 9, frame[24 - i], 1'b0);
         bb(i < 9, frame[24 - i], 1'b1);
         chk({promSerialClockPin, promChipSelectPin}, 2'h3, "sw clock pin");
         if (i >= 9) begin
            repeat (4) @(posedge ref_clk);
            rd(OFS_PROM_CTRL);
            word = {word[14:0], rdVal[3]};
         end
      end
      wr(OFS_PROM_CTRL, 16'h0010);
      chk(word, 16'h4567, "sw prom read");
      wr(OFS_PROM_CTRL, 16'h0000);
      $display("test prom software access done");
   endtask

   task automatic t_soft_rst();
      wr(OFS_SOFT_RST, 16'h0003);
      repeat (20) @(posedge ref_clk);
      chk({queueMgrReset, globalReset}, 2'h3, "both resets held");
      wr(OFS_SOFT_RST, 16'h0002);
      chk({queueMgrReset, globalReset}, 2'h2, "queue reset only");
      rd(OFS_SOFT_RST);
      chk(rdVal, 16'h0002, "reset readback");
      wr(OFS_SOFT_RST, 16'hfffc);
      rd(OFS_SOFT_RST);
      chk(rdVal, 0, "reserved reset bits");
      $display("test soft reset done");
   endtask

   task automatic t_no_prom();
      wr(OFS_SOFT_RST, 16'h0001);
      pullUp <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      frames = 0;
      for (int i = 0; i < 800; i++) begin
         @(posedge ref_clk);
         frames += promChipSelectPin;
      end
      chk(frames, 0, "no loader without prom");
      chk(stationAddr, 0, "address cleared by reset");
      chk(globalReset, 0, "global reset cleared");
      rd(OFS_CHIP_CFG);
      chk(rdVal & 16'h0200, 0, "presence clear");
      rd(OFS_SELFTEST);
      chk(rdVal, 16'h1010, "self-test after reset");
      $display("test no prom done");
   endtask

   ////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cycleCnt++;
      if (cycleCnt == 90000) begin
         errorCnt++;
         $display("unexpected at %0t: run timed out", $time);
         print_verdict();
      end
   end

   initial begin
      {rst_n, regWr, regRd, regAddr, regWdata} = '0;
      pullUp = 1'b1;
      errorCnt = 0;
      samplesChecked = 0;
      cycleCnt = 0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset_vals();
      t_load();
      t_addr_rw();
      t_bus_clk();
      t_prom_sw();
      t_soft_rst();
      t_no_prom();
      print_verdict();
   end
endmodule
